// ### verilog/scps_params.svh
`ifndef SCPS_PARAMS_SVH
`define SCPS_PARAMS_SVH

// register indices; byte address is four times the index
`define SCPS_IDX_BMC 6'h06
`define SCPS_IDX_DATA 6'h08
`define SCPS_IDX_PRS 6'h0c
`define SCPS_IDX_PRIP 6'h0d
`define SCPS_IDX_PRIE 6'h0e

// block master control fields
`define SCPS_BMC_MRST 0
`define SCPS_BMC_GIE 1

// protocol status fields
`define SCPS_PRS_TSC 0
`define SCPS_PRS_TSM 1
`define SCPS_PRS_GPH 2
`define SCPS_PRS_ACTIVITY_FLAG 3
`define SCPS_PRS_PWR 4
`define SCPS_PRS_SMB 5

// protocol event pending fields
`define SCPS_EV_CV 0
`define SCPS_EV_LINE_CONTENTION_EVENT 1
`define SCPS_EV_EOM 2
`define SCPS_EV_NULL 3
`define SCPS_EV_CWT 4
`define SCPS_EV_TMO 5
`define SCPS_EV_TSW 6
`define SCPS_EV_DCNT 7

// reset values
`define SCPS_PRS_RESET 8'h00
`define SCPS_PRIP_RESET 8'h00
`define SCPS_PRIE_RESET 8'h00

// bus answers and data window size
`define SCPS_RESP_OKAY 2'h0
`define SCPS_RESP_SLVERR 2'h2
`define SCPS_WIN_BYTES 3'h4

`endif

// ### verilog/scps_pkg.sv
`default_nettype none

package scps_pkg;

   typedef enum logic [2:0] {
      SCPS_IDLE,
      SCPS_WR_PUSH,
      SCPS_WR_RESP,
      SCPS_RD_POP,
      SCPS_RD_RESP
   } scps_state_t;

   typedef logic [7:0] scps_byte_t;

   typedef struct packed {
      scps_state_t st;
      logic last_wr;
      logic [7:0] waddr;
      logic have_aw;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic have_w;
      logic [7:0] raddr;
      logic have_ar;
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [2:0] rx_left;
      logic rx_ready;
      logic global_interrupt_enable;
      logic mrst;
      scps_byte_t enable;
      logic activity;
      logic conv;
      logic conv_cap;
      logic irq;
   } scps_regs_t;

endpackage : scps_pkg

`default_nettype wire

// ### verilog/scps_evt_flag.sv
`timescale 1ns/1ps
`default_nettype none

module scps_evt_flag #(
   parameter int WIDTH = 8
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic [WIDTH-1:0] set, // hardware events
   input wire logic [WIDTH-1:0] clr, // software clear
   output logic [WIDTH-1:0] q // sticky flags
);
   typedef struct packed {
      logic [WIDTH-1:0] flag;
   } scps_flag_t;

   scps_flag_t q_r;
   scps_flag_t q_nxt;

   // set beats clear so an event in the clearing cycle survives
   always_comb begin
      q_nxt = q_r;
      q_nxt.flag = set | (q_r.flag & ~clr);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign q = q_r.flag;
endmodule : scps_evt_flag

`default_nettype wire

// ### verilog/scps_lane_seq.sv
`timescale 1ns/1ps
`default_nettype none

module scps_lane_seq #(
   parameter int BYTES = 4
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic load, // start a word
   input wire logic [8*BYTES-1:0] load_word, // word to send
   input wire logic [BYTES-1:0] load_mask, // lanes present
   output logic out_valid, // byte offered
   output logic [7:0] out_data, // byte value
   input wire logic out_ready, // byte taken
   output logic busy // lanes remain
);
   typedef struct packed {
      logic [8*BYTES-1:0] word;
      logic [BYTES-1:0] mask;
   } scps_lane_t;

   scps_lane_t q_r;
   scps_lane_t q_nxt;

   // lowest lane leaves first; absent lanes are skipped one per cycle
   always_comb begin
      q_nxt = q_r;
      if (load && q_r.mask == '0) begin
         q_nxt.word = load_word;
         q_nxt.mask = load_mask;
      end else if (q_r.mask != '0 && (!q_r.mask[0] || out_ready)) begin
         q_nxt.word = q_r.word >> 8;
         q_nxt.mask = q_r.mask >> 1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign out_valid = q_r.mask[0];
   assign out_data = q_r.word[7:0];
   assign busy = |q_r.mask;
endmodule : scps_lane_seq

`default_nettype wire

// ### verilog/scps_regs.sv
// Functional notes
// - data window routes every access to FIFO
// - multi-byte access equals byte accesses, LSB first
// - status bits 7:6 and 4 read zero
// - bit 5 shows transfer in progress
// - activity set on receive, cleared by zero write
// - activity needs only receive enable
// - bit 2 shows guard reload phase
// - bit 1 shows direct or inverse convention
// - bit 0 set when convention auto-captured
// - ATR mode write clears both convention flags
// - pending 7 on down counter event
// - pending 6 on TS wait guard expiry
// - pending 5 on timeout timer expiry
// - pending 4 on character wait timeout
// - pending 3 on NULL procedure byte
// - pending 2 on end of message
// - pending 1 on line contention
// - pending 0 never requests an interrupt
// - code violation sources set pending 0
// - reading pending clears all, withdraws requests
// - pending requests gated by enable bits
// - global enable zero blocks all requests
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "scps_params.svh"

module scps_regs (
   input wire logic aclk, // system clock, 125 MHz
   input wire logic aresetn, // sync reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte lanes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic tx_byte_valid, // byte to transmit FIFO
   output scps_pkg::scps_byte_t tx_byte_data, // byte value
   input wire logic tx_byte_ready, // transmit FIFO takes byte
   input wire logic rx_byte_valid, // receive FIFO has byte
   input wire scps_pkg::scps_byte_t rx_byte_data, // received byte
   output logic rx_byte_ready, // pop receive FIFO
   input wire logic sm_busy, // protocol engine transfer busy
   input wire logic receive_enable_control, // receiver enabled
   input wire logic char_received, // pulse: character received
   input wire logic guard_phase, // 1: next reload from block guard time
   input wire logic atr_mode, // ATR mode active
   input wire logic atr_mode_set, // pulse: one written to ATR mode
   input wire logic ts_captured, // pulse: TS decoded
   input wire logic ts_inverse, // convention of captured TS
   input wire logic guard_expire, // pulse: guard timer expired
   input wire logic ts_waiting, // still waiting for TS
   input wire logic down_counter_event, // pulse: down counter interrupt
   input wire logic timeout_timer_event, // pulse: WWT/BWT/WTX timeout
   input wire logic char_wait_timer_event, // pulse: CWT or TS timeout
   input wire logic null_byte, // pulse: NULL procedure byte
   input wire logic end_of_message_event, // pulse: filter end of message
   input wire logic eom_error, // end of message was early or bad
   input wire logic line_contention_event, // pulse: I/O contention
   input wire logic bad_ts, // pulse: invalid TS in ATR
   input wire logic t0_filter_enable, // T=0 filter machine on
   input wire logic bad_proc_byte, // pulse: unknown procedure byte
   input wire logic early_first_status_byte, // pulse: early status byte
   output logic card_irq, // interrupt request, active high
   output logic block_reset // block master reset pulse
);
   import scps_pkg::*;

   scps_regs_t q_r;
   scps_regs_t q_nxt;

   logic blk_rst_n;
   logic lane_load;
   logic lane_busy;
   logic act_clr;
   logic [7:0] pend_set;
   logic [7:0] pend_clr;
   logic [7:0] pend_q;
   logic [7:0] status;
   logic [5:0] widx;
   logic [5:0] ridx;
   logic cv_set;

   // both resets clear status and pending state
   assign blk_rst_n = aresetn & ~q_r.mrst;

   assign widx = q_r.waddr[7:2];
   assign ridx = q_r.raddr[7:2];

   always_comb begin
      status = `SCPS_PRS_RESET;
      status[`SCPS_PRS_SMB] = sm_busy;
      status[`SCPS_PRS_ACTIVITY_FLAG] = q_r.activity;
      status[`SCPS_PRS_GPH] = guard_phase;
      status[`SCPS_PRS_TSM] = q_r.conv;
      status[`SCPS_PRS_TSC] = q_r.conv_cap;
   end

   // code violation also rides along with a failed end of message
   assign cv_set = bad_ts | (t0_filter_enable & (bad_proc_byte | early_first_status_byte))
      | (end_of_message_event & eom_error);

   always_comb begin
      pend_set = `SCPS_PRIP_RESET;
      pend_set[`SCPS_EV_DCNT] = down_counter_event;
      pend_set[`SCPS_EV_TSW] = guard_expire & atr_mode & ~guard_phase & ts_waiting;
      pend_set[`SCPS_EV_TMO] = timeout_timer_event;
      pend_set[`SCPS_EV_CWT] = char_wait_timer_event;
      pend_set[`SCPS_EV_NULL] = null_byte;
      pend_set[`SCPS_EV_EOM] = end_of_message_event;
      pend_set[`SCPS_EV_LINE_CONTENTION_EVENT] = line_contention_event;
      pend_set[`SCPS_EV_CV] = cv_set;
   end

   always_comb begin
      q_nxt = q_r;
      q_nxt.mrst = 1'b0;
      lane_load = 1'b0;
      act_clr = 1'b0;
      pend_clr = 8'h00;

      if (q_r.awready && s_axi_awvalid) begin
         q_nxt.waddr = s_axi_awaddr;
         q_nxt.have_aw = 1'b1;
      end
      if (q_r.wready && s_axi_wvalid) begin
         q_nxt.wdata = s_axi_wdata;
         q_nxt.wstrb = s_axi_wstrb;
         q_nxt.have_w = 1'b1;
      end
      if (q_r.arready && s_axi_arvalid) begin
         q_nxt.raddr = s_axi_araddr;
         q_nxt.have_ar = 1'b1;
      end

      case (q_r.st)
         SCPS_IDLE: begin
            // alternate priority so neither direction starves
            if (q_r.have_aw && q_r.have_w && (!q_r.have_ar || !q_r.last_wr)) begin
               q_nxt.last_wr = 1'b1;
               q_nxt.have_aw = 1'b0;
               q_nxt.have_w = 1'b0;
               q_nxt.bresp = `SCPS_RESP_OKAY;
               if (widx == `SCPS_IDX_DATA) begin
                  lane_load = 1'b1;
                  q_nxt.st = SCPS_WR_PUSH;
               end else begin
                  q_nxt.bvalid = 1'b1;
                  q_nxt.st = SCPS_WR_RESP;
                  if (widx == `SCPS_IDX_BMC) begin
                     if (q_r.wstrb[0]) begin
                        q_nxt.global_interrupt_enable = q_r.wdata[`SCPS_BMC_GIE];
                        q_nxt.mrst = q_r.wdata[`SCPS_BMC_MRST];
                     end
                  end else if (widx == `SCPS_IDX_PRS) begin
                     // only a zero to activity acts
                     act_clr = q_r.wstrb[0] & ~q_r.wdata[`SCPS_PRS_ACTIVITY_FLAG];
                  end else if (widx == `SCPS_IDX_PRIE) begin
                     if (q_r.wstrb[0]) begin
                        q_nxt.enable = q_r.wdata[7:0];
                     end
                  end else if (widx == `SCPS_IDX_PRIP) begin
                     q_nxt.bresp = `SCPS_RESP_OKAY;
                  end else begin
                     q_nxt.bresp = `SCPS_RESP_SLVERR;
                  end
               end
            end else if (q_r.have_ar) begin
               q_nxt.last_wr = 1'b0;
               q_nxt.have_ar = 1'b0;
               q_nxt.rresp = `SCPS_RESP_OKAY;
               q_nxt.rdata = 32'h0000_0000;
               if (ridx == `SCPS_IDX_DATA) begin
                  // a word read pops four bytes
                  q_nxt.rx_left = `SCPS_WIN_BYTES;
                  q_nxt.rx_ready = 1'b1;
                  q_nxt.st = SCPS_RD_POP;
               end else begin
                  q_nxt.rvalid = 1'b1;
                  q_nxt.st = SCPS_RD_RESP;
                  if (ridx == `SCPS_IDX_BMC) begin
                     q_nxt.rdata[`SCPS_BMC_GIE] = q_r.global_interrupt_enable;
                     q_nxt.rdata[`SCPS_BMC_MRST] = q_r.mrst;
                  end else if (ridx == `SCPS_IDX_PRS) begin
                     q_nxt.rdata[7:0] = status;
                  end else if (ridx == `SCPS_IDX_PRIP) begin
                     q_nxt.rdata[7:0] = pend_q;
                     pend_clr = 8'hff;
                  end else if (ridx == `SCPS_IDX_PRIE) begin
                     q_nxt.rdata[7:0] = q_r.enable;
                  end else begin
                     q_nxt.rresp = `SCPS_RESP_SLVERR;
                  end
               end
            end
         end
         SCPS_WR_PUSH: begin
            // answer only after every byte has entered the FIFO
            if (!lane_busy) begin
               q_nxt.bvalid = 1'b1;
               q_nxt.st = SCPS_WR_RESP;
            end
         end
         SCPS_WR_RESP: begin
            if (s_axi_bready) begin
               q_nxt.bvalid = 1'b0;
               q_nxt.st = SCPS_IDLE;
            end
         end
         SCPS_RD_POP: begin
            // stalls while the receive FIFO is empty
            if (rx_byte_valid) begin
               q_nxt.rdata = {rx_byte_data, q_r.rdata[31:8]};
               q_nxt.rx_left = q_r.rx_left - 3'h1;
               if (q_r.rx_left == 3'h1) begin
                  q_nxt.rx_ready = 1'b0;
                  q_nxt.rvalid = 1'b1;
                  q_nxt.st = SCPS_RD_RESP;
               end
            end
         end
         SCPS_RD_RESP: begin
            if (s_axi_rready) begin
               q_nxt.rvalid = 1'b0;
               q_nxt.st = SCPS_IDLE;
            end
         end
         default: begin
            q_nxt.st = SCPS_IDLE;
         end
      endcase

      q_nxt.awready = ~q_nxt.have_aw;
      q_nxt.wready = ~q_nxt.have_w;
      q_nxt.arready = ~q_nxt.have_ar;

      // receive-only qualification; fifo receive enable does not matter
      q_nxt.activity = (char_received & receive_enable_control)
         | (q_r.activity & ~act_clr);

      // capture wins over the ATR restart in the same cycle
      if (ts_captured) begin
         q_nxt.conv = ts_inverse;
         q_nxt.conv_cap = 1'b1;
      end else if (atr_mode_set) begin
         q_nxt.conv = 1'b0;
         q_nxt.conv_cap = 1'b0;
      end

      if (q_r.mrst) begin
         q_nxt.activity = 1'b0;
         q_nxt.conv = 1'b0;
         q_nxt.conv_cap = 1'b0;
      end

      // code violation bit is masked off: status only
      q_nxt.irq = q_r.global_interrupt_enable & (|(pend_q[7:1] & q_r.enable[7:1]))
         & ~pend_clr[0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   scps_evt_flag #(
      .WIDTH(8)
   ) u_pending (
      .aclk(aclk),
      .aresetn(blk_rst_n),
      .set(pend_set),
      .clr(pend_clr),
      .q(pend_q)
   );

   scps_lane_seq #(
      .BYTES(4)
   ) u_tx_lanes (
      .aclk(aclk),
      .aresetn(blk_rst_n),
      .load(lane_load),
      .load_word(q_r.wdata),
      .load_mask(q_r.wstrb),
      .out_valid(tx_byte_valid),
      .out_data(tx_byte_data),
      .out_ready(tx_byte_ready),
      .busy(lane_busy)
   );

   assign s_axi_awready = q_r.awready;
   assign s_axi_wready = q_r.wready;
   assign s_axi_arready = q_r.arready;
   assign s_axi_bvalid = q_r.bvalid;
   assign s_axi_bresp = q_r.bresp;
   assign s_axi_rvalid = q_r.rvalid;
   assign s_axi_rresp = q_r.rresp;
   assign s_axi_rdata = q_r.rdata;
   assign rx_byte_ready = q_r.rx_ready;
   assign card_irq = q_r.irq;
   assign block_reset = q_r.mrst;
endmodule : scps_regs

`default_nettype wire

// ### tb/scps_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "scps_params.svh"

module scps_regs_sva (
   input wire logic aclk, aresetn, // clock, sync reset
   input wire logic [7:0] s_axi_awaddr, s_axi_araddr, // bus addresses
   input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, // write hs
   input wire logic [31:0] s_axi_wdata, s_axi_rdata, // bus data
   input wire logic [3:0] s_axi_wstrb, // write lanes
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_bvalid, // read hs, write response valid
   input wire logic tx_byte_valid, tx_byte_ready, // transmit hs
   input wire scps_pkg::scps_byte_t tx_byte_data, // transmit byte
   input wire logic sm_busy, guard_phase, card_irq, block_reset, // status, irq
   input wire logic guard_expire, down_counter_event, timeout_timer_event, // events
   input wire logic char_wait_timer_event, null_byte, end_of_message_event, // events
   input wire logic line_contention_event, bad_ts, bad_proc_byte, early_first_status_byte // events
);
   import scps_pkg::*;
   logic src_any;
   logic ev_any;
   logic [5:0] rd_idx_r;
   logic [2:0] quiet_r;
   assign src_any = guard_expire | down_counter_event | timeout_timer_event
      | char_wait_timer_event | null_byte | end_of_message_event | line_contention_event;
   assign ev_any = src_any | bad_ts | bad_proc_byte | early_first_status_byte;
   // quiet counts cycles with no irq-capable event and no write offered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_idx_r <= 6'h00;
         quiet_r <= 3'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) rd_idx_r <= s_axi_araddr[7:2];
         if (src_any || s_axi_awvalid) quiet_r <= 3'h0;
         else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_irq_clr;
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == `SCPS_IDX_PRIP && !ev_any)
         ##1 !ev_any ##1 !ev_any |-> ##1 !card_irq;
   endproperty
   a_irq_clr: assert property (p_irq_clr) else $error("irq kept after pending read");
   property p_gie_off;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
         && s_axi_awaddr[7:2] == `SCPS_IDX_BMC && !s_axi_wdata[1] |-> ##4 !card_irq [*4];
   endproperty
   a_gie_off: assert property (p_gie_off) else $error("irq with global enable off");
   property p_cv_quiet;
      quiet_r == 3'h7 |-> !$rose(card_irq);
   endproperty
   a_cv_quiet: assert property (p_cv_quiet) else $error("irq rose without source");
   property p_tx_hold;
      tx_byte_valid && !tx_byte_ready |=> tx_byte_valid && $stable(tx_byte_data);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped or changed");
   property p_busy;
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == `SCPS_IDX_PRS)
         ##1 ($stable(sm_busy) && $stable(guard_phase)) [*2]
         |-> s_axi_rvalid && s_axi_rdata[5] == sm_busy && s_axi_rdata[2] == guard_phase;
   endproperty
   a_busy: assert property (p_busy) else $error("status busy or phase wrong");
   property p_prs_zero;
      s_axi_rvalid && rd_idx_r == `SCPS_IDX_PRS |-> s_axi_rdata[31:6] == 26'h0 && !s_axi_rdata[4];
   endproperty
   a_prs_zero: assert property (p_prs_zero) else $error("status zero bits set");
   property p_reset;
      disable iff (1'b0) !aresetn |=> !card_irq && !s_axi_bvalid && !s_axi_rvalid
         && !tx_byte_valid && !block_reset;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs active after reset");
   property p_mrst;
      block_reset && !ev_any ##1 !ev_any |-> ##1 !card_irq;
   endproperty
   a_mrst: assert property (p_mrst) else $error("irq kept after block reset");
   c_irq: cover property ($rose(card_irq));
   c_tx: cover property (tx_byte_valid && tx_byte_ready);
   c_mrst: cover property (block_reset);
endmodule : scps_regs_sva

bind scps_regs scps_regs_sva i_sva (.*);

`default_nettype wire

// ### tb/scps_card_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module scps_card_fifo (
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset, active low
   input wire logic slow, // answer every other cycle
   input wire logic tx_byte_valid, // byte offered
   input wire scps_pkg::scps_byte_t tx_byte_data, // byte value
   output logic tx_byte_ready, // byte taken
   output logic rx_byte_valid, // byte available
   output scps_pkg::scps_byte_t rx_byte_data, // byte value
   input wire logic rx_byte_ready // byte popped
);
   import scps_pkg::*;
   scps_byte_t tx_q[$];
   scps_byte_t rx_cnt_r;
   logic tick_r;
   logic rx_valid_r;
   assign tx_byte_ready = aresetn && (!slow || tick_r);
   assign rx_byte_valid = rx_valid_r;
   // idle data shows the inverse so a stale byte cannot match by luck
   assign rx_byte_data = rx_valid_r ? rx_cnt_r : ~rx_cnt_r;
   always @(posedge aclk) begin
      if (!aresetn) begin
         tick_r <= 1'b0;
         rx_valid_r <= 1'b0;
         rx_cnt_r <= 8'h10;
      end else begin
         tick_r <= !tick_r;
         if (tx_byte_valid && tx_byte_ready) tx_q.push_back(tx_byte_data);
         if (rx_valid_r && rx_byte_ready) rx_cnt_r <= rx_cnt_r + 8'h01;
         if (!rx_valid_r || rx_byte_ready) rx_valid_r <= !slow || !tick_r;
      end
   end
endmodule : scps_card_fifo

`default_nettype wire

// ### tb/scps_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "scps_params.svh"

module scps_regs_test;
   import scps_pkg::*;
   localparam logic [7:0] A_BMC = {`SCPS_IDX_BMC, 2'b00};
   localparam logic [7:0] A_DAT = {`SCPS_IDX_DATA, 2'b00};
   localparam logic [7:0] A_PRS = {`SCPS_IDX_PRS, 2'b00};
   localparam logic [7:0] A_PRP = {`SCPS_IDX_PRIP, 2'b00};
   localparam logic [7:0] A_PRE = {`SCPS_IDX_PRIE, 2'b00};
   localparam logic [1:0] OK = `SCPS_RESP_OKAY;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic slow = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic tx_byte_valid, tx_byte_ready, rx_byte_valid, rx_byte_ready, card_irq, block_reset;
   scps_byte_t tx_byte_data, rx_byte_data;
   logic sm_busy = 1'b0, receive_enable_control = 1'b0, guard_phase = 1'b0, atr_mode = 1'b0;
   logic ts_inverse = 1'b0, ts_waiting = 1'b0, eom_error = 1'b0, t0_filter_enable = 1'b0;
   logic [12:0] ev = 13'h0000;
   wire logic atr_mode_set, ts_captured, char_received, early_first_status_byte, bad_proc_byte;
   wire logic down_counter_event, guard_expire, timeout_timer_event, char_wait_timer_event;
   wire logic null_byte, end_of_message_event, line_contention_event, bad_ts;
   logic [7:0] txe [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hbb, 8'hdd};
   logic [31:0] e;
   int n_mismatch = 0;
   int total_checks = 0;
   assign {atr_mode_set, ts_captured, char_received, early_first_status_byte, bad_proc_byte,
      down_counter_event, guard_expire, timeout_timer_event, char_wait_timer_event,
      null_byte, end_of_message_event, line_contention_event, bad_ts} = ev;

   scps_regs i_dut (.*);
   scps_card_fifo i_far (.*);

   always #4 aclk = ~aclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) aw = 1'b1;
         if (s_axi_wready) w = 1'b1;
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
      end while (!(aw && w));
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, OK});
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, x);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : axi_rd

   task automatic pulse(input int i);
      @(posedge aclk);
      ev[i] <= 1'b1;
      @(posedge aclk);
      ev <= 13'h0000;
   endtask : pulse

   // pending lands one edge after the pulse, irq one edge later
   task automatic irq_is(input logic x);
      repeat (3) @(posedge aclk);
      chk({31'h0, card_irq}, {31'h0, x});
   endtask : irq_is

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      final_report();
   end

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(A_PRS, 32'h0, OK);
      axi_rd(A_PRP, 32'h0, OK);
      axi_rd(8'h3c, 32'h0, `SCPS_RESP_SLVERR);
      sm_busy <= 1'b1;
      guard_phase <= 1'b1;
      axi_wr(A_PRS, 32'hffff_fff7, 4'hf);
      axi_rd(A_PRS, 32'h24, OK);
      sm_busy <= 1'b0;
      guard_phase <= 1'b0;
      receive_enable_control <= 1'b1;
      pulse(10);
      axi_rd(A_PRS, 32'h08, OK);
      axi_wr(A_PRS, 32'hff, 4'hf);
      axi_rd(A_PRS, 32'h08, OK);
      axi_wr(A_PRS, 32'h00, 4'hf);
      axi_rd(A_PRS, 32'h00, OK);
      ts_inverse <= 1'b1;
      pulse(11);
      axi_rd(A_PRS, 32'h03, OK);
      pulse(12);
      axi_rd(A_PRS, 32'h00, OK);
      ts_inverse <= 1'b0;
      pulse(11);
      axi_rd(A_PRS, 32'h01, OK);
      atr_mode <= 1'b1;
      ts_waiting <= 1'b1;
      t0_filter_enable <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         pulse(i);
         e = (i < 8) ? 32'h1 << i : 32'h1;
         axi_rd(A_PRP, e, OK);
         axi_rd(A_PRP, 32'h0, OK);
      end
      eom_error <= 1'b1;
      pulse(2);
      axi_rd(A_PRP, 32'h05, OK);
      eom_error <= 1'b0;
      axi_wr(A_PRE, 32'hff, 4'hf);
      axi_wr(A_BMC, 32'h02, 4'h1);
      pulse(7);
      irq_is(1'b1);
      axi_rd(A_PRP, 32'h80, OK);
      irq_is(1'b0);
      pulse(0);
      irq_is(1'b0);
      axi_rd(A_PRP, 32'h01, OK);
      axi_wr(A_PRE, 32'h7f, 4'hf);
      pulse(7);
      irq_is(1'b0);
      axi_rd(A_PRP, 32'h80, OK);
      axi_wr(A_PRE, 32'hff, 4'hf);
      axi_wr(A_BMC, 32'h00, 4'h1);
      pulse(1);
      irq_is(1'b0);
      axi_wr(A_BMC, 32'h02, 4'h1);
      irq_is(1'b1);
      pulse(10);
      pulse(5);
      axi_wr(A_BMC, 32'h03, 4'h1);
      axi_rd(A_PRS, 32'h0, OK);
      axi_rd(A_PRP, 32'h0, OK);
      slow <= 1'b1;
      axi_wr(A_DAT, 32'h4433_2211, 4'hf);
      axi_wr(A_DAT, 32'hddcc_bbaa, 4'ha);
      chk(i_far.tx_q.size(), 32'h6);
      foreach (txe[k]) chk({24'h0, i_far.tx_q.pop_front()}, {24'h0, txe[k]});
      axi_rd(A_DAT, 32'h1312_1110, OK);
      slow <= 1'b0;
      axi_rd(A_DAT, 32'h1716_1514, OK);
      final_report();
   end
endmodule : scps_regs_test

`default_nettype wire
